// ### hw/dssr_pkg.sv
package dssr_pkg;
    localparam int CHAIN_LEN    = 8;
    localparam int NUM_CHAINS   = 2;
    localparam int SYNC_STAGES  = 2;
    localparam int BUF_DEPTH    = 2;
    localparam logic SEL_A      = 1'b0;
    localparam logic RESET_ACT  = 1'b0;
    localparam logic [CHAIN_LEN-1:0] CHAIN_CLEAR = 8'h00;

    // per-chain output word carried through the buffer
    typedef struct packed {
        logic [CHAIN_LEN-1:0] stages;
        logic                 q_true;
        logic                 q_inv;
    } dssr_word_t;

    // one input sample, all pins of the part
    typedef struct packed {
        logic                  input_select;
        logic [NUM_CHAINS-1:0] serial_input_a;
        logic [NUM_CHAINS-1:0] serial_input_b;
        logic [NUM_CHAINS-1:0] private_chain_clock;
        logic                  common_clock;
        logic                  reset_n;
    } dssr_pins_t;
endpackage

// ### hw/dssr_buf.sv
`timescale 1ns/1ps
// two-entry buffer, valid/ready on both sides
module dssr_buf #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    rd_reg, rd_next, wr_reg, wr_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // handshake and pointer advance
    always_comb begin
        in_ready  = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
        out_valid = (cnt_reg != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_next   = wr_reg;
        rd_next   = rd_reg;
        cnt_next  = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // pointer, count and memory write registers; read data is combinational
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_reg   <= '0;
            rd_reg   <= '0;
            cnt_reg  <= '0;
        end else begin
            wr_reg   <= wr_next;
            rd_reg   <= rd_next;
            cnt_reg  <= cnt_next;
        end
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    assign out_data = mem_reg[rd_reg];
endmodule

// ### hw/dssr_top.sv
`timescale 1ns/1ps
module dssr_top
    import dssr_pkg::*;
#(
    parameter int LEN = dssr_pkg::CHAIN_LEN
) (
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic                      input_select,
    input  wire logic [NUM_CHAINS-1:0]     serial_input_a,
    input  wire logic [NUM_CHAINS-1:0]     serial_input_b,
    input  wire logic [NUM_CHAINS-1:0]     private_chain_clock,
    input  wire logic                      common_clock,
    input  wire logic                      chain_reset_n,
    output logic      [NUM_CHAINS-1:0]     q_true,
    output logic      [NUM_CHAINS-1:0]     q_inv,
    output logic      [NUM_CHAINS-1:0]     word_valid,
    input  wire logic [NUM_CHAINS-1:0]     word_ready,
    output dssr_pkg::dssr_word_t [NUM_CHAINS-1:0] word_data,
    output logic      [NUM_CHAINS-1:0]     word_drop
);
    import dssr_pkg::*;

    localparam int PW = $bits(dssr_pins_t);

    dssr_pins_t           pins_now;
    logic [PW-1:0]        sync1_reg, sync2_reg;
    dssr_pins_t           pins_s;
    logic [NUM_CHAINS-1:0] eclk, eclk_prev_reg, rise;

    // pack asynchronous pins for synchronising
    always_comb begin
        pins_now.input_select        = input_select;
        pins_now.serial_input_a      = serial_input_a;
        pins_now.serial_input_b      = serial_input_b;
        pins_now.private_chain_clock = private_chain_clock;
        pins_now.common_clock        = common_clock;
        pins_now.reset_n             = chain_reset_n;
    end

    // two-flop synchroniser for all pins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins_now;
            sync2_reg <= sync1_reg;
        end
    end

    assign pins_s = dssr_pins_t'(sync2_reg);

    // effective clock and edge detection per chain
    always_comb begin
        for (int c = 0; c < NUM_CHAINS; c++) begin
            eclk[c] = pins_s.private_chain_clock[c] | pins_s.common_clock;
        end
        rise = eclk & ~eclk_prev_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            eclk_prev_reg <= '0;
        end else begin
            eclk_prev_reg <= eclk;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CHAINS; g++) begin : g_chain
            logic [LEN-1:0] chain_reg, chain_next;
            logic           din;
            logic           push_reg, push_next;
            logic           drop_reg, drop_next;
            logic           in_ready;
            dssr_word_t     w_reg, w_next;

            // input mux and shift step
            always_comb begin
                din = (pins_s.input_select == SEL_A) ?
                      pins_s.serial_input_a[g] :
                      pins_s.serial_input_b[g];
                chain_next = chain_reg;
                push_next  = 1'b0;
                // a snapshot offered to a full buffer is lost here
                drop_next  = push_reg & ~in_ready;
                w_next     = w_reg;
                if (pins_s.reset_n == RESET_ACT) begin
                    chain_next = CHAIN_CLEAR[LEN-1:0];
                end else if (rise[g]) begin
                    chain_next = {chain_reg[LEN-2:0], din};
                    push_next  = 1'b1;
                    w_next.stages = {chain_reg[LEN-2:0], din};
                    w_next.q_true = chain_reg[LEN-2];
                    w_next.q_inv  = ~chain_reg[LEN-2];
                end
            end

            // chain state registers
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    chain_reg <= '0;
                    push_reg  <= 1'b0;
                    drop_reg  <= 1'b0;
                    w_reg     <= '0;
                end else begin
                    chain_reg <= chain_next;
                    push_reg  <= push_next;
                    drop_reg  <= drop_next;
                    w_reg     <= w_next;
                end
            end

            // eighth stage on true and inverted pins
            assign q_true[g]    = chain_reg[LEN-1];
            assign q_inv[g]     = ~chain_reg[LEN-1];
            assign word_drop[g] = drop_reg;

            // snapshot after each shift, buffered toward the reader
            dssr_buf #(
                .WIDTH ($bits(dssr_word_t)),
                .DEPTH (BUF_DEPTH)
            ) u_buf (
                .clk_sys   (clk_sys),
                .reset     (reset),
                .in_valid  (push_reg),
                .in_ready  (in_ready),
                .in_data   (w_reg),
                .out_valid (word_valid[g]),
                .out_ready (word_ready[g]),
                .out_data  (word_data[g])
            );
        end
    endgenerate
endmodule

// ### tb/dssr_reader.sv
`timescale 1ns/1ps
// far-side reader of both word buffers
module dssr_reader (
    input  wire logic       stall,
    output logic      [1:0] word_ready
);
    // both readers hold off while stalled
    assign word_ready = stall ? 2'h0 : 2'h3;
endmodule

// ### tb/dssr_sva.sv
`timescale 1ns/1ps
module dssr_sva
    import dssr_pkg::*;
(
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic [1:0]       private_chain_clock,
    input wire logic             common_clock,
    input wire logic             chain_reset_n,
    input wire logic [1:0]       q_true,
    input wire logic [1:0]       q_inv,
    input wire logic [1:0]       word_valid,
    input wire logic [1:0]       word_ready,
    input wire dssr_word_t [1:0] word_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [2:0] quiet_reg, quiet_next;
    logic [1:0] eff_reg, eff_now;
    // cycles since a clock rise or a chain clear
    always_comb begin
        eff_now = private_chain_clock | {2{common_clock}};
        quiet_next = quiet_reg + {2'h0, quiet_reg != 3'h7};
        if (|(eff_now & ~eff_reg) || !chain_reset_n) quiet_next = 3'h0;
    end
    always_ff @(posedge clk_sys) begin
        eff_reg <= reset ? 2'h0 : eff_now;
        quiet_reg <= reset ? 3'h0 : quiet_next;
    end
    inv_out_a: assert property (q_inv == ~q_true)
        else $error("q_inv wrong");
    chain_clear_a: assert property (!chain_reset_n [*4] |-> !q_true)
        else $error("not cleared");
    no_shift_a: assert property (quiet_reg == 3'h7 |-> $stable(q_true))
        else $error("stray shift");
    word_tail_a: assert property (word_valid[1] |->
        word_data[1].q_true == word_data[1].stages[7]) else $error("tail");
    word_hold_a: assert property (word_valid[0] && !word_ready[0] |=>
        $stable(word_data[0])) else $error("word moved");
    own_clock_a: assert property ($rose(private_chain_clock[1]) &&
        !common_clock && !word_valid[1] |-> ##[2:6] word_valid[1])
        else $error("no private shift");
    all_clock_a: assert property ($rose(common_clock) && !word_valid &&
        !private_chain_clock |-> ##[2:6] word_valid == 2'h3)
        else $error("no common shift");
    cover property (word_valid == 2'h3 && !word_ready);
    cover property (quiet_reg == 3'h7 && q_true != 2'h0);
    cover property (!chain_reset_n [*4]);
endmodule
bind dssr_top dssr_sva dssr_sva_inst (.clk_sys, .reset, .private_chain_clock,
    .common_clock, .chain_reset_n, .q_true, .q_inv, .word_valid,
    .word_ready, .word_data);

// ### tb/dssr_top_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    cmp_count++; \
    if ((s) !== (e)) begin \
        err_total++; \
        $display("Error %s exp %h got %h", n, e, s); \
    end \
end
module dssr_top_bench;
    import dssr_pkg::*;
    logic             clk_sys = 1'b0;
    logic             reset = 1'b1;
    logic             input_select = 1'b0;
    logic             common_clock = 1'b0;
    logic             chain_reset_n = 1'b1;
    logic             stall = 1'b0;
    logic [1:0]       serial_input_a = 2'h0;
    logic [1:0]       serial_input_b = 2'h0;
    logic [1:0]       private_chain_clock = 2'h0;
    logic [1:0]       q_true, word_valid, word_ready, word_drop;
    int               drops = 0;
    dssr_word_t [1:0] word_data;
    logic [7:0]       exp_chain [2] = '{8'h00, 8'h00};
    logic [7:0]       snap;
    int               err_total = 0;
    int               cmp_count = 0;
    // select, a, b, clock mask (3 = common)
    logic [6:0]       rows [16] = '{7'h31, 7'h4e, 7'h13, 7'h4b, 7'h65, 7'h26,
        7'h33, 7'h73, 7'h3f, 7'h40, 7'h4f, 7'h31, 7'h2e, 7'h5b, 7'h33, 7'h7f};
    always #20 clk_sys = ~clk_sys;
    dssr_top dssr_top_inst (.clk_sys, .reset, .input_select, .serial_input_a,
        .serial_input_b, .private_chain_clock, .common_clock, .chain_reset_n,
        .q_true, .q_inv(), .word_valid, .word_ready, .word_data, .word_drop);
    // count lost snapshots of chain 0
    always @(negedge clk_sys) if (word_drop[0]) drops++;
    dssr_reader dssr_reader_inst (.stall, .word_ready);
    // data first, then one clock pulse, then update the model
    task automatic step(input logic [6:0] r);
        input_select = r[6];
        serial_input_a = r[5:4];
        serial_input_b = r[3:2];
        @(negedge clk_sys);
        if (r[1:0] == 2'h3) common_clock = 1'b1;
        else private_chain_clock = r[1:0];
        repeat (4) @(negedge clk_sys);
        common_clock = 1'b0;
        private_chain_clock = 2'h0;
        repeat (5) @(negedge clk_sys);
        for (int c = 0; c < 2; c++)
            if (r[c]) exp_chain[c] = {exp_chain[c][6:0], r[6] ? r[2+c] : r[4+c]};
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (3) @(negedge clk_sys);
        foreach (rows[i]) begin
            step(rows[i]);
            `CHK("q_true", {exp_chain[1][7], exp_chain[0][7]}, q_true);
        end
        stall = 1'b1;
        step(7'h13);
        snap = exp_chain[0];
        step(7'h33);
        step(7'h13);
        `CHK("word_valid", 2'h3, word_valid);
        `CHK("stages", snap, word_data[0].stages);
        `CHK("drops", 1, drops);
        stall = 1'b0;
        serial_input_b = 2'h3;
        chain_reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK("q_true", 2'h0, q_true);
        conclude();
    end
    // watchdog, about five times the expected run
    initial begin
        #40000;
        err_total++;
        conclude();
    end
endmodule
